/* hdl/qbp_port_set.sv */
// Functional notes
// - write strobe loads port latch from data
// - read-latch strobe returns stored latch value
// - reads pick latch or pin per request
// - bit inputs only while latch holds one
// - ports 1-6 weakly pulled high, overridable
// - port 0 high driver only on bus
// - port 0 latch one floats the pin
// - alternate function passes only with latch one
// - reset sets every latch bit to one
// - ports 0/2 switched to bus by control
// - bus mode: port 0 latch ones, port 2 kept
// - 16-bit address drives port 2 strongly
// - port 0 general I/O without bus cycles
// - port 2 quasi port, or address output
// - port 1 map: irq/capcomp, timer2, clock
// - port 3 map: serial, irq, timers, strobes
// - synchronous serial: data and shift clock
// - port 4 carries compare register outputs
// - port 5 carries concurrent compare outputs
// - port 6: converter start, serial 1
// - narrow address: port 2 emits its latch
`timescale 1ns/1ps
`default_nettype none
module qbp_port_set #(
    parameter int W = qbp_pkg::PORT_W,
    parameter int N = qbp_pkg::NUM_PORTS
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire qbp_pkg::qbp_cpu_req_s cpu_i,
    output logic [W-1:0] rd_data_o,
    input wire qbp_pkg::qbp_bus_s bus_i,
    input wire logic ext_program_select_n_i,
    output logic bus_active_o,
    output logic [W-1:0] bus_rd_data_o,
    input wire qbp_pkg::qbp_alt_out_s alt_out_i,
    output qbp_pkg::qbp_alt_in_s alt_in_o,
    input wire logic [N-1:0][W-1:0] pin_in_i,
    output logic [N-1:0][W-1:0] pin_out_o,
    output logic [N-1:0][W-1:0] pin_oe_o,
    output logic [N-1:0][W-1:0] pin_pu_o
);
    // ==================================================
    // pin synchronisers and program select strap
    logic [N-1:0][W-1:0] pin_s;
    logic [0:0] ext_sel_s;

    qbp_sync #(
        .W(N*W)
    ) u_pin_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .d_i(pin_in_i),
        .q_o(pin_s)
    );

    qbp_sync #(
        .W(1)
    ) u_sel_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .d_i(ext_program_select_n_i),
        .q_o(ext_sel_s)
    );

    // ==================================================
    // external bus switch-over
    logic ext_code;
    logic bus_active;

    // external code when strap low or pc past internal rom
    assign ext_code = ~ext_sel_s[0] | bus_i.pc_beyond_rom;
    // bus owns ports 0 and 2 only during real bus cycles
    assign bus_active = (bus_i.code_fetch & ext_code) |
                        bus_i.data_xfer;
    assign bus_active_o = bus_active;

    // ==================================================
    // port latches
    logic [N-1:0][W-1:0] latch_q;
    logic [N-1:0] wr_sel;
    logic [N-1:0] force_ones;

    // one write strobe per port register
    function automatic logic [N-1:0] port_dec(input logic [2:0] sel);
        logic [N-1:0] onehot;
        onehot = '0;
        for (int k = 0; k < N; k++) begin
            if (sel == k[2:0]) begin
                onehot[k] = 1'b1;
            end
        end
        return onehot;
    endfunction

    assign wr_sel = cpu_i.wr ? port_dec(cpu_i.sel) : '0;

    generate
        for (genvar p = 0; p < N; p++) begin : g_latch
            // port 0 latch is filled with ones while on the bus
            assign force_ones[p] = (p == 0) ? bus_active : 1'b0;
            qbp_port_latch #(
                .W(W),
                .RESET_VAL(qbp_pkg::LATCH_RESET)
            ) u_latch (
                .mclk_i(mclk_i),
                .rstn_i(rstn_i),
                .wr_i(wr_sel[p]),
                .force_ones_i(force_ones[p]),
                .data_i(cpu_i.data),
                .q_o(latch_q[p])
            );
        end
    endgenerate

    // ==================================================
    // register read path
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_o <= qbp_pkg::ALL_ZEROS;
        end else if (cpu_i.rd_latch) begin
            rd_data_o <= latch_q[cpu_i.sel];
        end else if (cpu_i.rd_pin) begin
            rd_data_o <= pin_s[cpu_i.sel];
        end
    end

    // data read back from the multiplexed low byte
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_rd_data_o <= qbp_pkg::ALL_ZEROS;
        end else if (bus_active && !bus_i.lo_drive) begin
            bus_rd_data_o <= pin_s[qbp_pkg::PORT0];
        end
    end

    // ==================================================
    // alternate output vectors, ones where a bit is input only
    logic [N-1:0][W-1:0] alt_v;

    always_comb begin
        alt_v = '1;
        // port 1 capture/compare channels and clock out
        alt_v[1][qbp_pkg::P1_CAPCOMP_LSB +: qbp_pkg::P1_CAPCOMP_W] =
            alt_out_i.capcomp_out;
        alt_v[1][qbp_pkg::P1_SYSCLK_BIT] =
            alt_out_i.sysclk_out_pin;
        // port 3 serial 0, data in sync mode, strobes
        alt_v[3][qbp_pkg::P3_RX_BIT] = alt_out_i.serial0_sync_mode ?
            alt_out_i.serial0_data_out : 1'b1;
        alt_v[3][qbp_pkg::P3_TX_BIT] = alt_out_i.serial0_tx;
        alt_v[3][qbp_pkg::P3_WR_BIT] = alt_out_i.wr_strobe_n;
        alt_v[3][qbp_pkg::P3_RD_BIT] = alt_out_i.rd_strobe_n;
        // port 4 and port 5 compare outputs
        alt_v[4] = alt_out_i.compare_reg_out;
        alt_v[5] = alt_out_i.concurrent_cmp_out;
        // port 6 serial 1 transmit
        alt_v[6][qbp_pkg::P6_TX_BIT] = alt_out_i.serial1_tx;
    end

    // ==================================================
    // alternate inputs, taken from synchronised pins
    always_comb begin
        alt_in_o.ext_irq_in =
            pin_s[1][qbp_pkg::P1_CAPCOMP_LSB +: qbp_pkg::P1_CAPCOMP_W];
        alt_in_o.capcomp_ch_pin =
            pin_s[1][qbp_pkg::P1_CAPCOMP_LSB +: qbp_pkg::P1_CAPCOMP_W];
        alt_in_o.timer2_reload_trigger_in =
            pin_s[1][qbp_pkg::P1_RELOAD_BIT];
        alt_in_o.timer2_count_in = pin_s[1][qbp_pkg::P1_COUNT_BIT];
        alt_in_o.serial0_rx = pin_s[3][qbp_pkg::P3_RX_BIT];
        alt_in_o.ext_irq_zero_in = pin_s[3][qbp_pkg::P3_IRQ0_BIT];
        alt_in_o.ext_irq_one_in = pin_s[3][qbp_pkg::P3_IRQ1_BIT];
        alt_in_o.timer0_count_in = pin_s[3][qbp_pkg::P3_TMR0_BIT];
        alt_in_o.timer1_count_in = pin_s[3][qbp_pkg::P3_TMR1_BIT];
        alt_in_o.ext_conv_start_in = pin_s[6][qbp_pkg::P6_CONV_BIT];
        alt_in_o.serial1_rx = pin_s[6][qbp_pkg::P6_RX_BIT];
    end

    // ==================================================
    // pin driver decision
    logic [N-1:0][W-1:0] next_out;
    logic [N-1:0][W-1:0] next_oe;
    logic [N-1:0][W-1:0] next_pu;

    always_comb begin
        for (int p = 0; p < N; p++) begin
            // latch AND alternate: any zero pulls the pin down
            next_out[p] = latch_q[p] & alt_v[p];
            // strong pulldown only for zeros, ones stay inputs
            next_oe[p] = ~next_out[p];
            // weak pullup on ones, quasi-bidirectional
            next_pu[p] = next_out[p];
        end
        // port 0: open drain, never a pullup as general I/O
        next_pu[0] = qbp_pkg::ALL_ZEROS;
        if (bus_active) begin
            // address/data bus drives both levels itself
            next_out[0] = bus_i.lo_byte;
            next_oe[0] = bus_i.lo_drive ? qbp_pkg::ALL_ONES :
                qbp_pkg::ALL_ZEROS;
            if (bus_i.addr16) begin
                // high address byte with strong drive all cycle
                next_out[2] = bus_i.hi_byte;
                next_oe[2] = qbp_pkg::ALL_ONES;
                next_pu[2] = qbp_pkg::ALL_ZEROS;
            end
            // narrow address keeps port 2 on its latch
        end
    end

    // registered pin drive
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_out_o <= '1;
            pin_oe_o <= '0;
            // quasi ports start pulled up, port 0 floats from the start
            pin_pu_o <= '1;
            pin_pu_o[0] <= qbp_pkg::ALL_ZEROS;
        end else begin
            pin_out_o <= next_out;
            pin_oe_o <= next_oe;
            pin_pu_o <= next_pu;
        end
    end

    // ==================================================
    // checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    latch_write_a: assert property (
        (cpu_i.wr && !(cpu_i.sel == qbp_pkg::PORT0 && bus_active)
         && cpu_i.sel < 3'h7)
        |=> latch_q[$past(cpu_i.sel)] == $past(cpu_i.data))
        else $error("port latch missed a write");

    read_latch_a: assert property (
        (cpu_i.rd_latch && !cpu_i.wr && cpu_i.sel < 3'h7)
        |=> rd_data_o == $past(latch_q[cpu_i.sel]))
        else $error("latch read returned wrong value");

    read_pin_a: assert property (
        (cpu_i.rd_pin && !cpu_i.rd_latch && cpu_i.sel < 3'h7)
        |=> rd_data_o == $past(pin_s[cpu_i.sel]))
        else $error("pin read returned wrong value");

    p1_input_a: assert property (
        (latch_q[1] == qbp_pkg::ALL_ONES &&
         alt_v[1] == qbp_pkg::ALL_ONES)
        |=> pin_oe_o[1] == qbp_pkg::ALL_ZEROS &&
            pin_pu_o[1] == qbp_pkg::ALL_ONES)
        else $error("port 1 input bit not released");

    p0_pullup_a: assert property (
        pin_pu_o[0] == qbp_pkg::ALL_ZEROS)
        else $error("port 0 pullup switched on");

    p0_float_a: assert property (
        (!bus_active && latch_q[0] == qbp_pkg::ALL_ONES)
        |=> pin_oe_o[0] == qbp_pkg::ALL_ZEROS)
        else $error("port 0 one does not float");

    p0_force_a: assert property (
        bus_active |=> latch_q[0] == qbp_pkg::ALL_ONES)
        else $error("port 0 latch not filled with ones");

    p2_keep_a: assert property (
        (bus_active && !wr_sel[2]) |=> $stable(latch_q[2]))
        else $error("port 2 latch changed on bus");

    p2_addr_a: assert property (
        (bus_active && bus_i.addr16) |=>
        pin_oe_o[2] == qbp_pkg::ALL_ONES &&
        pin_out_o[2] == $past(bus_i.hi_byte))
        else $error("port 2 address byte not driven");

    p2_narrow_a: assert property (
        (bus_active && !bus_i.addr16) |=>
        pin_out_o[2] == $past(latch_q[2]))
        else $error("port 2 left its latch value");

    p3_gate_a: assert property (
        (latch_q[3][qbp_pkg::P3_TX_BIT] == 1'b0)
        ##1 (latch_q[3][qbp_pkg::P3_TX_BIT] == 1'b0)
        |-> pin_out_o[3][qbp_pkg::P3_TX_BIT] == 1'b0 &&
            pin_oe_o[3][qbp_pkg::P3_TX_BIT] == 1'b1)
        else $error("alternate output passed a zero latch");

    cmp_route_a: assert property (
        (latch_q[4] == qbp_pkg::ALL_ONES) |=>
        pin_out_o[4] == $past(alt_out_i.compare_reg_out))
        else $error("compare output not routed to port 4");

    write_cov_c: cover property (cpu_i.wr ##1 cpu_i.rd_latch);
    pin_cov_c: cover property (cpu_i.rd_pin && !cpu_i.rd_latch);
    bus16_cov_c: cover property (bus_active && bus_i.addr16);
    sync_cov_c: cover property (alt_out_i.serial0_sync_mode);
endmodule // qbp_port_set
`default_nettype wire

/* common/qbp_pkg.sv */
`default_nettype none
package qbp_pkg;
    // ==================================================
    // port geometry
    localparam int PORT_W = 8;
    localparam int NUM_PORTS = 7;
    localparam logic [7:0] LATCH_RESET = 8'hFF;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] ALL_ZEROS = 8'h00;
    // ==================================================
    // port indices
    localparam logic [2:0] PORT0 = 3'h0;
    localparam logic [2:0] PORT1 = 3'h1;
    localparam logic [2:0] PORT2 = 3'h2;
    localparam logic [2:0] PORT3 = 3'h3;
    localparam logic [2:0] PORT4 = 3'h4;
    localparam logic [2:0] PORT5 = 3'h5;
    localparam logic [2:0] PORT6 = 3'h6;
    // ==================================================
    // field positions of the multiplexed bits
    localparam int P1_CAPCOMP_LSB = 0;
    localparam int P1_CAPCOMP_W = 5;
    localparam int P1_RELOAD_BIT = 5;
    localparam int P1_SYSCLK_BIT = 6;
    localparam int P1_COUNT_BIT = 7;
    localparam int P3_RX_BIT = 0;
    localparam int P3_TX_BIT = 1;
    localparam int P3_IRQ0_BIT = 2;
    localparam int P3_IRQ1_BIT = 3;
    localparam int P3_TMR0_BIT = 4;
    localparam int P3_TMR1_BIT = 5;
    localparam int P3_WR_BIT = 6;
    localparam int P3_RD_BIT = 7;
    localparam int P6_CONV_BIT = 0;
    localparam int P6_RX_BIT = 1;
    localparam int P6_TX_BIT = 2;
    // ==================================================
    // processor side access
    typedef struct packed {
        logic [2:0] sel;
        logic wr;
        logic rd_latch;
        logic rd_pin;
        logic [7:0] data;
    } qbp_cpu_req_s;
    // external memory bus
    typedef struct packed {
        logic code_fetch;
        logic pc_beyond_rom;
        logic data_xfer;
        logic addr16;
        logic lo_drive;
        logic [7:0] lo_byte;
        logic [7:0] hi_byte;
    } qbp_bus_s;
    // peripheral outputs heading for pins
    typedef struct packed {
        logic [4:0] capcomp_out;
        logic sysclk_out_pin;
        logic serial0_sync_mode;
        logic serial0_data_out;
        logic serial0_tx;
        logic wr_strobe_n;
        logic rd_strobe_n;
        logic [7:0] compare_reg_out;
        logic [7:0] concurrent_cmp_out;
        logic serial1_tx;
    } qbp_alt_out_s;
    // pin levels handed to peripherals
    typedef struct packed {
        logic [4:0] ext_irq_in;
        logic [4:0] capcomp_ch_pin;
        logic timer2_reload_trigger_in;
        logic timer2_count_in;
        logic serial0_rx;
        logic ext_irq_zero_in;
        logic ext_irq_one_in;
        logic timer0_count_in;
        logic timer1_count_in;
        logic ext_conv_start_in;
        logic serial1_rx;
    } qbp_alt_in_s;
endpackage
`default_nettype wire

/* hdl/qbp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module qbp_sync #(
    parameter int W = 8
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // ==================================================
    // two stage synchroniser, first stage read only by second
    logic [W-1:0] meta;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= '1;
            q_o <= '1;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule // qbp_sync
`default_nettype wire

/* hdl/qbp_port_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module qbp_port_latch #(
    parameter int W = 8,
    parameter logic [W-1:0] RESET_VAL = '1
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic wr_i,
    input wire logic force_ones_i,
    input wire logic [W-1:0] data_i,
    output logic [W-1:0] q_o
);
    // ==================================================
    // d-type bit latches of one port
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q_o <= RESET_VAL;
        end else if (force_ones_i) begin
            q_o <= '1;
        end else if (wr_i) begin
            q_o <= data_i;
        end
    end
endmodule // qbp_port_latch
`default_nettype wire

/* sim/qbp_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// outside circuits on the pins of all seven ports
module qbp_pin_model (
    input wire logic mclk_i,
    input wire logic [6:0][7:0] pin_out_i,
    input wire logic [6:0][7:0] pin_oe_i,
    input wire logic [6:0][7:0] pin_pu_i,
    input wire logic [6:0][7:0] ext_en_i,
    input wire logic [6:0][7:0] ext_val_i,
    output logic [6:0][7:0] pin_o
);
    logic [6:0][7:0] last = '0;
    // strong drive wins, then an outside source, then the weak pullup
    // a zero driven from inside overrides any outside source
    // undriven open-drain lines wander instead of keeping a level
    always_comb begin
        for (int p = 0; p < 7; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (pin_oe_i[p][b]) begin
                    pin_o[p][b] = pin_out_i[p][b];
                end else if (ext_en_i[p][b]) begin
                    pin_o[p][b] = ext_val_i[p][b];
                end else if (pin_pu_i[p][b]) begin
                    pin_o[p][b] = 1'b1;
                end else begin
                    pin_o[p][b] = ~last[p][b];
                end
            end
        end
    end
    // remember the level so that floating lines toggle
    always_ff @(posedge mclk_i) begin
        last <= pin_o;
    end
endmodule // qbp_pin_model
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
// ==================================================
// bench for the port set
module tb_top;
    logic mclk_i, rstn_i, sel_n;
    qbp_pkg::qbp_cpu_req_s cpu;
    qbp_pkg::qbp_bus_s bus;
    qbp_pkg::qbp_alt_out_s alt;
    qbp_pkg::qbp_alt_in_s ain;
    logic [7:0] rdd, brd, d;
    logic bact;
    logic [6:0][7:0] pin_in, pout, poe, ppu, ext_en, ext_val;
    int num_errors = 0;
    int checks = 0;
    qbp_port_set u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .cpu_i(cpu),
        .rd_data_o(rdd), .bus_i(bus), .ext_program_select_n_i(sel_n),
        .bus_active_o(bact), .bus_rd_data_o(brd), .alt_out_i(alt),
        .alt_in_o(ain), .pin_in_i(pin_in), .pin_out_o(pout),
        .pin_oe_o(poe), .pin_pu_o(ppu));
    qbp_pin_model u_pins (.mclk_i(mclk_i), .pin_out_i(pout), .pin_oe_i(poe),
        .pin_pu_i(ppu), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .pin_o(pin_in));
    // clock at 250 MHz
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic wr_port(input logic [2:0] p, input logic [7:0] v);
        @(posedge mclk_i);
        cpu.sel <= p;
        cpu.wr <= 1'b1;
        cpu.data <= v;
        @(posedge mclk_i);
        cpu.wr <= 1'b0;
        tick(2);
    endtask
    task automatic rd_port(input logic [2:0] p, input logic lt,
                           output logic [7:0] v);
        @(posedge mclk_i);
        cpu.sel <= p;
        cpu.rd_latch <= lt;
        cpu.rd_pin <= ~lt;
        @(posedge mclk_i);
        cpu.rd_latch <= 1'b0;
        cpu.rd_pin <= 1'b0;
        tick(1);
        v = rdd;
    endtask
    task automatic give_verdict();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // latches come out of reset holding ones
    task automatic t_reset();
        for (int p = 0; p < 7; p++) begin
            rd_port(p[2:0], 1'b1, d);
            `CHK(d, 8'hFF)
            `CHK(poe[p], 8'h00)
            `CHK(ppu[p], (p == 0) ? 8'h00 : 8'hFF)
        end
        $display("test reset done");
    endtask
    // latch versus pin reads with an outside source on port 1
    task automatic t_rw();
        wr_port(3'h1, 8'h5A);
        @(posedge mclk_i);
        ext_en[1] <= 8'h5A; // outside drives only latch-one bits
        ext_val[1] <= 8'h0F;
        tick(4);
        `CHK(poe[1], 8'hA5)
        rd_port(3'h1, 1'b1, d);
        `CHK(d, 8'h5A)
        rd_port(3'h1, 1'b0, d);
        `CHK(d, 8'h0A)
        wr_port(3'h0, 8'h00);
        `CHK(poe[0], 8'hFF)
        `CHK(pout[0], 8'h00)
        $display("test read write done");
    endtask
    // peripheral outputs gated with the latches
    task automatic t_alt_out();
        wr_port(3'h1, 8'hFF);
        wr_port(3'h4, 8'hF0);
        wr_port(3'h5, 8'h0F);
        @(posedge mclk_i);
        ext_en <= '0;
        alt <= {5'h0A, 3'b001, 3'b001, 8'h33, 8'hC5, 1'b0};
        tick(2);
        `CHK(ppu[1], 8'hAA)
        `CHK(ppu[3], 8'hBD)
        `CHK(ppu[4], 8'h30)
        `CHK(poe[4], 8'hCF)
        `CHK(ppu[5], 8'h05)
        `CHK(ppu[6], 8'hFB)
        @(posedge mclk_i);
        alt.serial0_sync_mode <= 1'b1;
        alt.serial0_data_out <= 1'b0;
        alt.serial0_tx <= 1'b1;
        tick(2);
        `CHK(ppu[3], 8'hBE)
        // a zero latch holds the shift clock line low
        wr_port(3'h3, 8'hFD);
        `CHK(pout[3], 8'hBC)
        `CHK(poe[3], 8'h43)
        wr_port(3'h3, 8'hFF);
        $display("test alternate outputs done");
    endtask
    // pin levels handed to peripherals
    task automatic t_alt_in();
        @(posedge mclk_i);
        alt <= '1;
        ext_en[1] <= 8'hFF;
        ext_val[1] <= 8'hA5;
        ext_en[3] <= 8'hFF;
        ext_val[3] <= 8'h35;
        ext_en[6] <= 8'hFF;
        ext_val[6] <= 8'h02;
        tick(5);
        `CHK(ain.capcomp_ch_pin, 5'h05)
        `CHK(ain.ext_irq_in, 5'h05)
        `CHK({ain.timer2_reload_trigger_in, ain.timer2_count_in},
             2'b11)
        `CHK({ain.serial0_rx, ain.ext_irq_zero_in, ain.ext_irq_one_in,
              ain.timer0_count_in, ain.timer1_count_in}, 5'h1B)
        `CHK({ain.ext_conv_start_in, ain.serial1_rx}, 2'b01)
        $display("test alternate inputs done");
    endtask
    // ports 0 and 2 taken over by the external bus
    task automatic t_bus();
        wr_port(3'h2, 8'h3C);
        @(posedge mclk_i);
        ext_en <= '0;
        bus <= {4'b0011, 1'b1, 8'hC3, 8'h96};
        tick(2);
        `CHK(bact, 1'b1)
        `CHK({pout[0], poe[0]}, 16'hC3FF)
        `CHK({pout[2], poe[2], ppu[2]}, 24'h96FF00)
        wr_port(3'h0, 8'h00);
        @(posedge mclk_i);
        bus.addr16 <= 1'b0;
        bus.lo_drive <= 1'b0;
        ext_en[0] <= 8'hFF;
        ext_val[0] <= 8'h5E;
        tick(4);
        `CHK({poe[0], poe[2], ppu[2]}, 24'h00C33C)
        `CHK(brd, 8'h5E)
        @(posedge mclk_i);
        bus <= '0;
        ext_en[0] <= 8'h00;
        tick(2);
        rd_port(3'h0, 1'b1, d);
        `CHK(d, 8'hFF)
        rd_port(3'h2, 1'b1, d);
        `CHK(d, 8'h3C)
        `CHK({poe[0], ppu[2]}, 16'h003C)
        @(posedge mclk_i);
        bus.code_fetch <= 1'b1;
        tick(4);
        `CHK(bact, 1'b0)
        @(posedge mclk_i);
        bus.pc_beyond_rom <= 1'b1;
        tick(1);
        `CHK(bact, 1'b1)
        @(posedge mclk_i);
        bus.pc_beyond_rom <= 1'b0;
        sel_n <= 1'b0;
        tick(4);
        `CHK(bact, 1'b1)
        $display("test external bus done");
    endtask
    // watchdog well beyond the expected run
    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end
    // main sequence
    initial begin
        rstn_i = 1'b0;
        sel_n = 1'b1;
        cpu = '0;
        bus = '0;
        alt = '1;
        ext_en = '0;
        ext_val = '0;
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
        tick(2);
        t_reset();
        t_rw();
        t_alt_out();
        t_alt_in();
        t_bus();
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
